// file: design/sbs_defines.vh
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH

// ==========================================================
// snooped transaction codes
`define SBS_CMD_NULL 2'h0
`define SBS_CMD_READ 2'h1
`define SBS_CMD_WRITE 2'h2
`define SBS_CMD_XCHG 2'h3

// ==========================================================
// register byte offsets
`define SBS_OFF_CTRL 8'h00
`define SBS_OFF_STAT 8'h04
`define SBS_OFF_MASK 8'h08
`define SBS_OFF_LOCK 8'h0C
`define SBS_OFF_INFO 8'h10

// ==========================================================
// field positions
`define SBS_CTRL_IO_COND 0
`define SBS_ERR_SBUS 0
`define SBS_ERR_DTAG 1
`define SBS_ERR_TAG 2
`define SBS_ERR_EDC 3
`define SBS_ERR_W 4
`define SBS_LOCK_VALID 31

// ==========================================================
// reset values
`define SBS_CTRL_RST 32'h0000_0000
`define SBS_ERR_RST 4'h0
`define SBS_MASK_RST 4'h0

`endif

// file: design/sbs_snoop_ctrl.v
`timescale 1ns/100ps
`include "sbs_defines.vh"

module sbs_snoop_ctrl #(
	parameter ADDR_W = 27
) (
	input wire clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire snp_start,
	input wire [1:0] snp_cmd,
	input wire [ADDR_W-1:0] snp_addr,
	input wire [ADDR_W-1:0] snp_xwr_addr,
	input wire snp_par,
	input wire snp_io_cmdr,
	input wire in_arb,
	input wire bc_gnt,
	input wire probe_done,
	input wire probe_hit,
	input wire probe_dirty,
	input wire probe_shared,
	input wire probe_perr,
	input wire dtag_hit,
	input wire dtag_perr,
	input wire data_done,
	input wire data_edc_err,
	input wire lock_set,
	input wire [ADDR_W-1:0] lock_set_addr,
	output reg bc_req_q,
	output reg probe_req_q,
	output reg [ADDR_W-1:0] probe_addr_q,
	output reg rsp_valid_q,
	output reg rsp_shared_q,
	output reg rsp_dirty_q,
	output reg data_supply_q,
	output reg tag_wr_q,
	output reg tag_wr_valid_q,
	output reg tag_wr_dirty_q,
	output reg tag_wr_shared_q,
	output reg tag_upd_data_q,
	output reg snp_done_q,
	output reg mchk_q,
	output reg irq_q
);

	// ==========================================================
	// states
	localparam ST_IDLE = 3'd0;
	localparam ST_OWN = 3'd1;
	localparam ST_PROBE = 3'd2;
	localparam ST_ACT = 3'd3;
	localparam ST_DATA = 3'd4;

	reg [2:0] st_q;
	reg [1:0] cmd_q;
	reg [ADDR_W-1:0] xwr_q;
	reg io_q;
	reg arb_q;
	reg hit_q;
	reg dirty_q;
	reg shared_q;
	reg dtag_hit_q;
	reg io_cond_q;
	reg [`SBS_ERR_W-1:0] err_q;
	reg [`SBS_ERR_W-1:0] mask_q;
	reg lock_valid_q;
	reg [ADDR_W-1:0] lock_addr_q;
	reg [15:0] snoop_cnt_q;
	reg [`SBS_ERR_W-1:0] err_set;
	reg lock_clr;
	reg [31:0] rd_data;

	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire par_bad = ^{snp_cmd, snp_addr, snp_xwr_addr, snp_par};

	function lock_match;
		input [ADDR_W-1:0] a;
		begin
			lock_match = lock_valid_q & (a == lock_addr_q);
		end
	endfunction

	function reg_hit;
		input [7:0] off;
		begin
			reg_hit = bus_req & (wb_adr_i == off);
		end
	endfunction

	// ==========================================================
	// snoop sequencer
	// probe address latched at start holds the read address of an exchange
	wire wr_update = io_cond_q ? dtag_hit_q : (dtag_hit_q | io_q | arb_q);

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= ST_IDLE;
			cmd_q <= `SBS_CMD_NULL;
			xwr_q <= {ADDR_W{1'b0}};
			io_q <= 1'b0;
			arb_q <= 1'b0;
			hit_q <= 1'b0;
			dirty_q <= 1'b0;
			shared_q <= 1'b0;
			dtag_hit_q <= 1'b0;
			bc_req_q <= 1'b0;
			probe_req_q <= 1'b0;
			probe_addr_q <= {ADDR_W{1'b0}};
			rsp_valid_q <= 1'b0;
			rsp_shared_q <= 1'b0;
			rsp_dirty_q <= 1'b0;
			data_supply_q <= 1'b0;
			tag_wr_q <= 1'b0;
			tag_wr_valid_q <= 1'b0;
			tag_wr_dirty_q <= 1'b0;
			tag_wr_shared_q <= 1'b0;
			tag_upd_data_q <= 1'b0;
			snp_done_q <= 1'b0;
			snoop_cnt_q <= 16'h0000;
		end
		else
		begin
			probe_req_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_shared_q <= 1'b0;
			rsp_dirty_q <= 1'b0;
			tag_wr_q <= 1'b0;
			tag_upd_data_q <= 1'b0;
			snp_done_q <= 1'b0;
			case (st_q)
				ST_IDLE:
				begin
					if (snp_start)
					begin
						cmd_q <= snp_cmd;
						probe_addr_q <= snp_addr;
						xwr_q <= snp_xwr_addr;
						io_q <= snp_io_cmdr;
						arb_q <= in_arb;
						snoop_cnt_q <= snoop_cnt_q + 16'h0001;
						if (snp_cmd == `SBS_CMD_NULL)
							snp_done_q <= 1'b1;
						else
						begin
							bc_req_q <= 1'b1;
							st_q <= ST_OWN;
						end
					end
				end
				ST_OWN:
				begin
					if (bc_gnt)
					begin
						probe_req_q <= 1'b1;
						st_q <= ST_PROBE;
					end
				end
				ST_PROBE:
				begin
					if (probe_done)
					begin
						hit_q <= probe_hit;
						dirty_q <= probe_dirty;
						shared_q <= probe_shared;
						dtag_hit_q <= dtag_hit;
						st_q <= ST_ACT;
					end
				end
				ST_ACT:
				begin
					rsp_valid_q <= 1'b1;
					st_q <= ST_IDLE;
					case (cmd_q)
						`SBS_CMD_READ:
						begin
							if (hit_q)
							begin
								rsp_shared_q <= 1'b1;
								rsp_dirty_q <= dirty_q;
								tag_wr_q <= ~shared_q;
								tag_wr_valid_q <= 1'b1;
								tag_wr_dirty_q <= dirty_q;
								tag_wr_shared_q <= 1'b1;
							end
							else
								rsp_shared_q <= lock_match(probe_addr_q);
						end
						`SBS_CMD_WRITE:
						begin
							if (hit_q)
							begin
								tag_wr_q <= 1'b1;
								tag_wr_dirty_q <= 1'b0;
								if (wr_update)
								begin
									tag_wr_valid_q <= 1'b1;
									tag_wr_shared_q <= shared_q;
									tag_upd_data_q <= 1'b1;
									rsp_shared_q <= 1'b1;
								end
								else
								begin
									tag_wr_valid_q <= 1'b0;
									tag_wr_shared_q <= 1'b0;
								end
							end
						end
						default:
						begin
							// exchange
							if (hit_q)
							begin
								rsp_shared_q <= 1'b1;
								rsp_dirty_q <= dirty_q;
							end
							else
								rsp_shared_q <= lock_match(probe_addr_q);
						end
					endcase
					if ((cmd_q != `SBS_CMD_WRITE) && hit_q && dirty_q)
					begin
						data_supply_q <= 1'b1;
						st_q <= ST_DATA;
					end
					else
					begin
						bc_req_q <= 1'b0;
						snp_done_q <= 1'b1;
					end
				end
				ST_DATA:
				begin
					if (data_done)
					begin
						data_supply_q <= 1'b0;
						bc_req_q <= 1'b0;
						snp_done_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default:
				begin
					st_q <= ST_IDLE;
					bc_req_q <= 1'b0;
					data_supply_q <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// lock clear and error detection
	always @*
	begin
		lock_clr = 1'b0;
		err_set = {`SBS_ERR_W{1'b0}};
		if (st_q == ST_ACT)
		begin
			if (cmd_q == `SBS_CMD_WRITE)
				lock_clr = lock_match(probe_addr_q);
			else if ((cmd_q == `SBS_CMD_XCHG) && !hit_q)
				lock_clr = lock_match(xwr_q);
		end
		if ((st_q == ST_IDLE) && snp_start)
			err_set[`SBS_ERR_SBUS] = par_bad;
		if ((st_q == ST_PROBE) && probe_done)
		begin
			err_set[`SBS_ERR_TAG] = probe_perr;
			err_set[`SBS_ERR_DTAG] = dtag_perr & (cmd_q == `SBS_CMD_WRITE);
		end
		if ((st_q == ST_DATA) && data_done)
			err_set[`SBS_ERR_EDC] = data_edc_err;
	end

	// ==========================================================
	// register file, wishbone slave with a registered one-cycle ack, raised one clock after the strobe
	always @*
	begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			`SBS_OFF_CTRL: rd_data[`SBS_CTRL_IO_COND] = io_cond_q;
			`SBS_OFF_STAT: rd_data[`SBS_ERR_W-1:0] = err_q;
			`SBS_OFF_MASK: rd_data[`SBS_ERR_W-1:0] = mask_q;
			`SBS_OFF_LOCK:
			begin
				rd_data[`SBS_LOCK_VALID] = lock_valid_q;
				rd_data[ADDR_W-1:0] = lock_addr_q;
			end
			`SBS_OFF_INFO:
			begin
				rd_data[15:0] = snoop_cnt_q;
				rd_data[18:16] = st_q;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			io_cond_q <= 1'b0;
			err_q <= `SBS_ERR_RST;
			mask_q <= `SBS_MASK_RST;
			lock_valid_q <= 1'b0;
			lock_addr_q <= {ADDR_W{1'b0}};
			mchk_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
			if (reg_hit(`SBS_OFF_CTRL) && wb_we_i && wb_sel_i[0])
				io_cond_q <= wb_dat_i[`SBS_CTRL_IO_COND];
			if (reg_hit(`SBS_OFF_MASK) && wb_we_i && wb_sel_i[0])
				mask_q <= wb_dat_i[`SBS_ERR_W-1:0];
			// a new error in the clearing cycle survives the clear
			if (reg_hit(`SBS_OFF_STAT) && wb_we_i && wb_sel_i[0])
				err_q <= (err_q & ~wb_dat_i[`SBS_ERR_W-1:0]) | err_set;
			else
				err_q <= err_q | err_set;
			mchk_q <= |err_set;
			irq_q <= |((err_q | err_set) & mask_q);
			// snoop clear beats a same-cycle set so a stale lock never survives
			if (lock_clr)
				lock_valid_q <= 1'b0;
			else if (lock_set)
			begin
				lock_valid_q <= 1'b1;
				lock_addr_q <= lock_set_addr;
			end
			else if (bus_wr && (wb_adr_i == `SBS_OFF_LOCK) && (wb_sel_i == 4'hF))
			begin
				lock_valid_q <= wb_dat_i[`SBS_LOCK_VALID];
				lock_addr_q <= wb_dat_i[ADDR_W-1:0];
			end
		end
	end

endmodule // sbs_snoop_ctrl

// file: sim/sbs_snoop_monitor.sv
`timescale 1ns/100ps
module sbs_snoop_monitor (
	input wire clk,
	input wire rst_n,
	input wire snp_start,
	input wire [1:0] snp_cmd,
	input wire bc_gnt,
	input wire probe_done,
	input wire probe_perr,
	input wire data_done,
	input wire bc_req_q,
	input wire probe_req_q,
	input wire rsp_valid_q,
	input wire rsp_shared_q,
	input wire rsp_dirty_q,
	input wire data_supply_q,
	input wire tag_wr_q,
	input wire tag_wr_valid_q,
	input wire tag_wr_dirty_q,
	input wire tag_wr_shared_q,
	input wire tag_upd_data_q,
	input wire snp_done_q,
	input wire mchk_q
);
// ========
// snoop sequencing
default clocking @(posedge clk);
endclocking
default disable iff (!rst_n);
chk_cache_take:
	assert property (snp_start && snp_cmd != 2'h0 && !bc_req_q |=> bc_req_q) else $error("no cache request");
chk_null_quiet:
	assert property (snp_start && snp_cmd == 2'h0 && !bc_req_q |=> snp_done_q && !bc_req_q) else $error("null acted");
chk_probe_gnt:
	assert property (probe_req_q |-> $past(bc_gnt) && bc_req_q) else $error("probe before grant");
chk_rsp_time:
	assert property (probe_done && bc_req_q |-> ##2 rsp_valid_q) else $error("late response");
chk_dirty_shared:
	assert property (rsp_valid_q && rsp_dirty_q |-> rsp_shared_q && data_supply_q) else $error("dirty alone");
chk_supply_hold:
	assert property (data_supply_q && !data_done |=> data_supply_q) else $error("supply dropped");
chk_inval_clean:
	assert property (tag_wr_q && !tag_wr_valid_q |-> !tag_wr_dirty_q && !tag_wr_shared_q) else $error("bad invalidate");
chk_update_data:
	assert property (tag_upd_data_q |-> tag_wr_q && tag_wr_valid_q && !tag_wr_dirty_q && rsp_shared_q)
		else $error("bad line update");
chk_perr_mchk:
	assert property (probe_done && probe_perr && bc_req_q |=> mchk_q) else $error("no machine check");
chk_done_release:
	assert property (snp_done_q |-> !bc_req_q && !data_supply_q ##1 !snp_done_q) else $error("cache held");
endmodule // sbs_snoop_monitor

bind sbs_snoop_ctrl sbs_snoop_monitor sbs_snoop_monitor_inst (.*);

// file: sim/sbs_far_side.sv
`timescale 1ns/100ps
module sbs_far_side (
	input wire clk,
	input wire bc_req_q,
	input wire probe_req_q,
	input wire data_supply_q,
	input wire [6:0] cfg,
	input wire [1:0] wait_n,
	output reg bc_gnt,
	output reg probe_done,
	output reg data_done,
	output wire probe_hit,
	output wire probe_dirty,
	output wire probe_shared,
	output wire probe_perr,
	output wire dtag_hit,
	output wire dtag_perr,
	output wire data_edc_err
);
reg [2:0] pc = 3'h0;
reg [2:0] dc = 3'h0;
// ========
// results flip outside their strobe so a mistimed sample shows
assign {dtag_perr, dtag_hit, probe_perr, probe_shared, probe_dirty, probe_hit} = probe_done ? cfg[5:0] : ~cfg[5:0];
assign data_edc_err = data_done ? cfg[6] : ~cfg[6];
always @(posedge clk)
begin
	bc_gnt <= bc_req_q;
	probe_done <= bc_req_q && pc == 3'h1;
	data_done <= data_supply_q && dc == 3'h1;
	if (!bc_req_q)
		pc <= 3'h0;
	else if (probe_req_q)
		pc <= {1'b0, wait_n} + 3'h1;
	else if (pc != 3'h0)
		pc <= pc - 3'h1;
	if (!data_supply_q)
		dc <= {1'b0, wait_n} + 3'h1;
	else if (dc != 3'h0)
		dc <= dc - 3'h1;
end
endmodule // sbs_far_side

// file: sim/sbs_snoop_ctrl_test.sv
`timescale 1ns/100ps
`include "sbs_defines.vh"
module sbs_snoop_ctrl_test;
typedef struct packed {
	logic [1:0] c;
	logic [6:0] f;
	logic i, a, l, x, m;
	logic [7:0] e;
	logic k;
} sbs_row_t;
logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, snp_start, snp_par, snp_io_cmdr, in_arb, lock_set, mc;
logic bc_gnt, probe_done, probe_hit, probe_dirty, probe_shared, probe_perr, dtag_hit, dtag_perr, data_done;
logic data_edc_err, bc_req_q, probe_req_q, rsp_valid_q, rsp_shared_q, rsp_dirty_q, data_supply_q, tag_wr_q;
logic tag_wr_valid_q, tag_wr_dirty_q, tag_wr_shared_q, tag_upd_data_q, snp_done_q, mchk_q, irq_q;
logic [1:0] snp_cmd, wait_n;
logic [3:0] wb_sel_i;
logic [6:0] cfg;
logic [7:0] wb_adr_i, got;
logic [31:0] wb_dat_i, wb_dat_o, rd;
logic [26:0] snp_addr, snp_xwr_addr, lock_set_addr, probe_addr_q, la, xw;
int bad_count, checks, i;
// cmd, probe result, io, arb, lock hit, xwr hit, io cond, response and tag, lock after
sbs_row_t rows [17] = '{'{1, 7'h03, 0, 0, 0, 0, 0, 8'hFF, 1}, '{1, 7'h01, 0, 0, 0, 0, 0, 8'hCD, 1},
	'{1, 7'h05, 0, 0, 0, 0, 0, 8'hC0, 1}, '{1, 7'h00, 0, 0, 1, 0, 0, 8'hC0, 1},
	'{1, 7'h00, 0, 0, 0, 0, 0, 8'h80, 1}, '{2, 7'h11, 0, 0, 1, 0, 0, 8'hCC, 0},
	'{2, 7'h05, 1, 0, 0, 0, 0, 8'hCD, 1}, '{2, 7'h01, 0, 1, 0, 0, 0, 8'hCC, 1},
	'{2, 7'h07, 0, 0, 1, 0, 0, 8'h88, 0}, '{2, 7'h00, 0, 0, 1, 0, 0, 8'h80, 0},
	'{3, 7'h03, 0, 0, 1, 1, 0, 8'hF0, 1}, '{3, 7'h01, 0, 0, 0, 0, 0, 8'hC0, 1},
	'{3, 7'h00, 0, 0, 1, 0, 0, 8'hC0, 1}, '{3, 7'h00, 0, 0, 0, 1, 0, 8'h80, 0},
	'{0, 7'h00, 0, 0, 0, 0, 0, 8'h00, 1}, '{2, 7'h01, 1, 0, 0, 0, 1, 8'h88, 1},
	'{2, 7'h11, 1, 0, 0, 0, 1, 8'hCC, 1}};
sbs_row_t errs [4] = '{'{0, 7'h00, 0, 0, 0, 0, 0, 8'h00, 0}, '{2, 7'h21, 0, 0, 0, 0, 0, 8'h00, 0},
	'{1, 7'h09, 0, 0, 0, 0, 0, 8'h00, 0}, '{1, 7'h43, 0, 0, 0, 0, 0, 8'h00, 0}};
always #50 clk = ~clk;
sbs_snoop_ctrl sbs_snoop_ctrl_inst (.*);
sbs_far_side sbs_far_side_inst (.*);
// ========
// shared tasks
task complete_run;
	begin
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
endtask
task hang;
	begin
		bad_count++;
		complete_run();
	end
endtask
task cmp(input logic [31:0] g, input logic [31:0] e);
	begin
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (wb_ack_o === 1'b1)
				break;
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (n == 20)
			hang();
		@(posedge clk);
	end
endtask
task automatic run_row(input sbs_row_t r, input logic p);
	int n;
	begin
		la = r.l ? snp_addr : 27'h000_5678;
		xw = r.x ? la : 27'h000_0F0F;
		wb(1'b1, `SBS_OFF_CTRL, {31'h0, r.m});
		{lock_set, lock_set_addr, cfg, snp_io_cmdr, in_arb} <= {1'b1, la, r.f, r.i, r.a};
		@(posedge clk);
		{lock_set, snp_start, snp_cmd, snp_xwr_addr} <= {2'b01, r.c, xw};
		// even parity over the whole transfer; p breaks it on purpose
		snp_par <= ^{r.c, snp_addr, xw, p};
		@(posedge clk);
		snp_start <= 1'b0;
		got = 8'h00;
		mc = 1'b0;
		for (n = 0; snp_done_q !== 1'b1; n++)
		begin
			@(negedge clk);
			if (rsp_valid_q === 1'b1)
				got = {4'hC, tag_wr_valid_q, tag_wr_dirty_q, tag_wr_shared_q, 1'b0};
			if (rsp_valid_q === 1'b1)
				got = {1'b1, rsp_shared_q, rsp_dirty_q, data_supply_q, tag_wr_q, got[3:1] & {3{tag_wr_q}}};
			mc |= mchk_q;
			if (n == 40)
				hang();
		end
		// the next bus request must start right after a rising edge
		@(posedge clk);
		mc |= mchk_q;
		wb(1'b0, `SBS_OFF_LOCK, 32'h0000_0000);
	end
endtask
// ========
// main sequence
initial
begin
	{clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, snp_start, snp_par, snp_io_cmdr, in_arb, lock_set} = 0;
	{wb_adr_i, wb_dat_i, snp_cmd, snp_xwr_addr, lock_set_addr, cfg, wait_n} = 0;
	bad_count = 0;
	checks = 0;
	wb_sel_i = 4'hF;
	snp_addr = 27'h000_1234;
	repeat (12) @(posedge clk);
	rst_n <= 1'b1;
	@(posedge clk);
	for (i = 0; i < 12; i += 4)
	begin
		wb(1'b0, i[7:0], 32'h0000_0000);
		cmp(rd, 32'h0000_0000);
	end
	wb(1'b0, 8'hFC, 32'h0000_0000);
	cmp(rd, 32'h0000_0000);
	$display("reset test done");
	for (i = 0; i < 17; i++)
	begin
		wait_n <= i[1:0];
		run_row(rows[i], 1'b0);
		cmp(got & (rows[i].c == 2'h3 ? 8'hF0 : 8'hFF), rows[i].e);
		cmp(rd[`SBS_LOCK_VALID], rows[i].k);
		cmp(probe_addr_q, snp_addr);
		$display("row %0d done", i);
	end
	wb(1'b0, `SBS_OFF_INFO, 32'h0000_0000);
	cmp(rd, 32'h0000_0011);
	wb(1'b1, `SBS_OFF_MASK, 32'h0000_000F);
	for (i = 0; i < 4; i++)
	begin
		run_row(errs[i], i == 0);
		wb(1'b0, `SBS_OFF_STAT, 32'h0000_0000);
		cmp(rd, 32'h1 << i);
		cmp({mc, irq_q}, 2'b11);
		wb(1'b1, `SBS_OFF_STAT, rd);
		wb(1'b0, `SBS_OFF_STAT, 32'h0000_0000);
		cmp({rd, irq_q}, 33'h0);
		$display("error %0d done", i);
	end
	wb(1'b1, `SBS_OFF_MASK, 32'h0000_0000);
	run_row(errs[0], 1'b1);
	wb(1'b0, `SBS_OFF_STAT, 32'h0000_0000);
	cmp({rd, irq_q}, 33'h2);
	$display("mask test done");
	// mid-run reset with a status bit and the lock still set
	rst_n <= 1'b0;
	repeat (2) @(posedge clk);
	rst_n <= 1'b1;
	@(posedge clk);
	wb(1'b0, `SBS_OFF_STAT, 32'h0000_0000);
	cmp({rd, irq_q}, 33'h0);
	wb(1'b0, `SBS_OFF_LOCK, 32'h0000_0000);
	cmp(rd, 32'h0000_0000);
	wb(1'b0, `SBS_OFF_INFO, 32'h0000_0000);
	cmp(rd, 32'h0000_0000);
	run_row(rows[0], 1'b0);
	cmp(got, rows[0].e);
	cmp(rd[`SBS_LOCK_VALID], rows[0].k);
	$display("mid reset test done");
	complete_run();
end
endmodule // sbs_snoop_ctrl_test
